//--- rtl/aecc_pkg.sv
// Shared constants, types and helpers for the extra-conversion control block.
// Assumes a single 40 MHz system clock and an APB register port.
package aecc_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0]  REG_IDX_SEQ   = 8'hb4;
  localparam logic [7:0]  REG_IDX_STAT  = 8'hb5;
  localparam logic [7:0]  REG_IDX_EXTRA = 8'hb6;
  localparam int          ADDR_W        = 12;

  // Field positions of the extra conversion control register.
  localparam int          EXT_REF_LSB   = 6;
  localparam int          EXT_DEC_LSB   = 4;
  localparam int          EXT_CH_LSB    = 0;
  // Field positions of the sequence register.
  localparam int          SEQ_DEC_LSB   = 4;
  localparam int          SEQ_START_BIT = 6;
  // Field positions of the status register.
  localparam int          STAT_SEQ_BIT  = 0;
  localparam int          STAT_PEND_BIT = 1;
  localparam int          STAT_EXT_BIT  = 2;
  localparam int          STAT_CH_LSB   = 4;

  // Values after reset.
  localparam logic [7:0]  EXTRA_RST     = 8'h00;
  localparam logic [7:0]  SEQ_RST       = 8'h00;

  // Channel code boundaries of a sequence.
  localparam logic [3:0]  CHAN_FIRST_SE   = 4'h0;
  localparam logic [3:0]  CHAN_FIRST_DIFF = 4'h8;
  localparam logic [3:0]  CHAN_SINGLE_MIN = 4'hc;

  // Clock cycles spent per decimation sample.
  localparam logic [11:0] CONV_CLKS_PER_SAMPLE = 12'h004;

  typedef enum logic [1:0] {
    REF_INT_1V25, REF_EXT_SE, REF_SUPPLY, REF_EXT_DIFF
  } aecc_ref_t;

  typedef enum logic [1:0] {DEC_64, DEC_128, DEC_256, DEC_512} aecc_dec_t;

  // One conversion setting: reference, decimation and channel.
  typedef struct packed {
    aecc_ref_t  refSel;
    aecc_dec_t  decSel;
    logic [3:0] chan;
  } aecc_conv_t;

  // Analog front end selects.
  typedef struct packed {
    logic [7:0] posSel;
    logic [7:0] negSel;
    logic       gndSel;
    logic       vrefSel;
    logic       tempSel;
    logic       vdd3Sel;
    logic [3:0] refOneHot;
  } aecc_mux_t;

  // Decimation rate of a code.
  function automatic logic [11:0] decimRate(aecc_dec_t d);
    decimRate = 12'h040 << d;
  endfunction

  // Resolution in bits of a decimation code.
  function automatic logic [3:0] resBitsOf(aecc_dec_t d);
    case (d)
      DEC_64:  resBitsOf = 4'h7;
      DEC_128: resBitsOf = 4'h9;
      DEC_256: resBitsOf = 4'ha;
      default: resBitsOf = 4'hc;
    endcase
  endfunction

  // Conversion length in clock cycles.
  function automatic logic [11:0] convCycles(aecc_dec_t d);
    convCycles = 12'(decimRate(d) * CONV_CLKS_PER_SAMPLE);
  endfunction

  // Byte address of a register index.
  function automatic logic [ADDR_W-1:0] regAddr(logic [7:0] idx);
    regAddr = {2'b00, idx, 2'b00};
  endfunction

endpackage

//--- rtl/aecc_conv.sv
// Conversion timer: runs one conversion whose length follows the decimation.
// Assumes start is a one-cycle pulse given only while busy is low.
`timescale 1ns/1ps
`default_nettype none
module aecc_conv
  import aecc_pkg::*;
(
  input  wire logic       clk,     // System clock.
  input  wire logic       rstN,    // Synchronised reset, active low.
  input  wire logic       start,   // Start pulse.
  input  wire aecc_dec_t  decim,   // Decimation code.
  output logic            busy,    // Conversion running.
  output logic            done,    // One-cycle pulse at the end.
  output logic [3:0]      resBits  // Resolution of the last result.
);

  logic [11:0] cnt_q;
  logic        busy_q;
  logic        done_q;
  logic [3:0]  res_q;

  // Load the length on start and count down to the end.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cnt_q  <= 12'h000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      res_q  <= 4'h0;
    end else begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        cnt_q  <= convCycles(decim) - 12'h001;
        busy_q <= 1'b1;
        res_q  <= resBitsOf(decim);
      end else if (busy_q) begin
        if (cnt_q == 12'h000) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 12'h001;
        end
      end
    end
  end

  assign busy    = busy_q;
  assign done    = done_q;
  assign resBits = res_q;

endmodule
`default_nettype wire

//--- rtl/aecc_mux_dec.sv
// Registered decoder from channel and reference codes to analog selects.
// Assumes the selects are sampled by the analog front end on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module aecc_mux_dec
  import aecc_pkg::*;
(
  input  wire logic       clk,    // System clock.
  input  wire logic       rstN,   // Synchronised reset, active low.
  input  wire aecc_conv_t cfg,    // Active conversion setting.
  output aecc_mux_t       muxSel  // Registered analog selects.
);

  aecc_mux_t dec_d;
  aecc_mux_t dec_q;

  // Map each channel code onto inputs, pairs or internal sources.
  always_comb begin
    dec_d = '0;
    if (cfg.chan < CHAN_FIRST_DIFF) begin
      dec_d.posSel[cfg.chan[2:0]] = 1'b1;
    end else if (cfg.chan < CHAN_SINGLE_MIN) begin
      dec_d.posSel[{cfg.chan[1:0], 1'b0}] = 1'b1;
      dec_d.negSel[{cfg.chan[1:0], 1'b1}] = 1'b1;
    end else begin
      case (cfg.chan[1:0])
        2'h0:    dec_d.gndSel  = 1'b1;
        2'h1:    dec_d.vrefSel = 1'b1;
        2'h2:    dec_d.tempSel = 1'b1;
        default: dec_d.vdd3Sel = 1'b1;
      endcase
    end
    dec_d.refOneHot[cfg.refSel] = 1'b1;
  end

  // Hold the decoded selects in flip-flops.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      dec_q <= '0;
    end else begin
      dec_q <= dec_d;
    end
  end

  assign muxSel = dec_q;

endmodule
`default_nettype wire

//--- rtl/aecc_top.sv
// Extra conversion control with a simple conversion sequencer and APB port.
// Assumes an APB master on sys_clk and an analog front end fed by muxSel.
// Assumes the front end samples muxSel and convCfg on sys_clk, and that
// software polls the channel field, which reads zero once the extra
// conversion it asked for has finished.
`timescale 1ns/1ps
`default_nettype none
module aecc_top
  import aecc_pkg::*;
(
  input  wire logic              sys_clk,    // System clock, 40 MHz.
  input  wire logic              arst_n,     // Asynchronous reset, low.
  input  wire logic              psel,       // APB select.
  input  wire logic              penable,    // APB enable.
  input  wire logic              pwrite,     // APB write.
  input  wire logic [ADDR_W-1:0] paddr,      // APB byte address.
  input  wire logic [31:0]       pwdata,     // APB write data.
  output logic [31:0]            prdata,     // APB read data.
  output logic                   pready,     // APB ready.
  output logic                   pslverr,    // APB error.
  output aecc_conv_t             convCfg,    // Active conversion setting.
  output aecc_mux_t              muxSel,     // Analog front end selects.
  output logic                   convActive, // A conversion is running.
  output logic                   convDone,   // Conversion end pulse.
  output logic [3:0]             resBits     // Resolution of last result.
);

  // Scheduler states: idle, stepping a sequence, or running the extra one.
  typedef enum logic [1:0] {ST_IDLE, ST_SEQ, ST_EXTRA} aecc_state_t;

  // Reset synchroniser. Only the second flip-flop drives the block, so a
  // release of arst_n close to a clock edge cannot leave part of the state
  // in reset.
  logic        rstMeta_q;
  logic        rstN;

  // Register state. The extra setting and its pending flag are kept apart
  // so that a rewrite during a running extra conversion queues another, which
  // runs on channel zero, as the end of the running one clears the channel.
  aecc_conv_t  extra_q;
  logic [7:0]  seqCfg_q;
  logic        extraPend_q;
  logic        seqPend_q;
  aecc_state_t state_q;
  aecc_state_t state_d;
  aecc_conv_t  active_q;
  aecc_conv_t  active_d;
  logic        start_q;
  logic        start_d;
  logic [31:0] prdata_q;

  // Bus decode. Every transfer takes two cycles, as pready is tied high.
  // No register needs more time, so the slave never stalls the master.
  logic        setup;
  logic        access;
  logic        wrExtra;
  logic        wrSeq;
  logic        hitExtra;
  logic        hitSeq;
  logic        hitStat;

  // Sequence settings and converter handshake. The timer reports its end
  // as a one-cycle pulse, which is the only event the scheduler follows.
  logic [3:0]  seqEnd;
  aecc_dec_t   seqDec;
  logic        seqAllowed;
  logic [3:0]  seqFirst;
  logic        convBusy;
  logic        convEnd;
  logic        extraEnd;

  // Release the asynchronous reset through two flip-flops.
  // Assertion takes effect at once; release takes two rising edges, after
  // which the first bus transfer may begin.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_q <= 1'b0;
      rstN      <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN      <= rstMeta_q;
    end
  end

  // Address decode; the slave answers with no wait state.
  // An unmapped address raises pslverr in the access phase and is ignored,
  // so a stray write can never start a conversion.
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign hitExtra = (paddr == regAddr(REG_IDX_EXTRA));
  assign hitSeq   = (paddr == regAddr(REG_IDX_SEQ));
  assign hitStat  = (paddr == regAddr(REG_IDX_STAT));
  assign pready   = 1'b1;
  assign pslverr  = access && !(hitExtra || hitSeq || hitStat);
  assign wrExtra  = access && pwrite && hitExtra;
  assign wrSeq    = access && pwrite && hitSeq;

  // Sequence register fields.
  // End codes from the single-channel range cannot form a sequence, so a
  // start with such an end code is dropped rather than left pending for
  // ever.
  assign seqEnd     = seqCfg_q[3:0];
  assign seqDec     = aecc_dec_t'(seqCfg_q[SEQ_DEC_LSB +: 2]);
  assign seqAllowed = (seqEnd < CHAN_SINGLE_MIN);
  assign seqFirst   = (seqEnd < CHAN_FIRST_DIFF) ? CHAN_FIRST_SE
                                                 : CHAN_FIRST_DIFF;

  // Events of the extra conversion. The end pulse clears the channel field
  // only when it belongs to the extra conversion, not to a sequence step.
  assign convEnd    = convDone;
  assign extraEnd   = convEnd && (state_q == ST_EXTRA);

  // Extra conversion control register; a write in the same cycle as the
  // end of a conversion wins over the clearing of the channel.
  // Software reads the channel field back to learn whether its request is
  // still outstanding.
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      extra_q <= aecc_conv_t'(EXTRA_RST);
    end else if (wrExtra) begin
      extra_q.refSel <= aecc_ref_t'(pwdata[EXT_REF_LSB +: 2]);
      extra_q.decSel <= aecc_dec_t'(pwdata[EXT_DEC_LSB +: 2]);
      extra_q.chan   <= pwdata[EXT_CH_LSB +: 4];
    end else if (extraEnd) begin
      extra_q.chan <= 4'h0;
    end
  end

  // Pending request for an extra conversion; a new write wins over the
  // clear when the previous request is taken in the same cycle.
  // The flag drops on the cycle the scheduler takes the request, not at the
  // end, so a rewrite during the run is kept as a new request.
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      extraPend_q <= 1'b0;
    end else if (wrExtra) begin
      extraPend_q <= 1'b1;
    end else if (start_d && (state_d == ST_EXTRA)) begin
      extraPend_q <= 1'b0;
    end
  end

  // Sequence configuration and its start request.
  // The reference bits are stored as zero, so every sequence step uses the
  // internal reference.
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      seqCfg_q  <= SEQ_RST;
      seqPend_q <= 1'b0;
    end else begin
      if (wrSeq) begin
        seqCfg_q <= {2'b00, pwdata[5:0]};
      end
      if (wrSeq && pwdata[SEQ_START_BIT]) begin
        seqPend_q <= 1'b1;
      end else if (start_d && (state_d == ST_SEQ)
                   && (state_q != ST_SEQ)) begin
        seqPend_q <= 1'b0;
      end else if (!seqAllowed) begin
        seqPend_q <= 1'b0;
      end
    end
  end

  // Conversion scheduler: sequence steps first, then a waiting extra one.
  // An extra request that arrives during a sequence waits for the end of
  // the last step. From idle it is taken at once, ahead of a sequence
  // start pending in the same cycle. Each start is a one-cycle pulse given
  // only while the timer is quiet.
  always_comb begin
    state_d  = state_q;
    active_d = active_q;
    start_d  = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (extraPend_q) begin
          state_d  = ST_EXTRA;
          active_d = extra_q;
          start_d  = 1'b1;
        end else if (seqPend_q && seqAllowed) begin
          state_d         = ST_SEQ;
          active_d.refSel = aecc_ref_t'(seqCfg_q[7:6]);
          active_d.decSel = seqDec;
          active_d.chan   = seqFirst;
          start_d         = 1'b1;
        end
      end
      ST_SEQ: begin
        if (convEnd) begin
          if (active_q.chan != seqEnd) begin
            active_d.chan = active_q.chan + 4'h1;
            start_d       = 1'b1;
          end else if (extraPend_q) begin
            state_d  = ST_EXTRA;
            active_d = extra_q;
            start_d  = 1'b1;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_EXTRA: begin
        if (convEnd) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Scheduler state.
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Setting of the conversion that runs or has just run.
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      active_q <= '0;
    end else begin
      active_q <= active_d;
    end
  end

  // Start pulse to the conversion timer. It is registered, so the setting
  // in active_q is already stable when the timer loads its length.
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_d;
    end
  end

  // Read data are captured in the setup phase and shown in the access.
  // Capturing early keeps prdata a flip-flop output that stays steady
  // through the whole access phase and after it.
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= 32'h0000_0000;
      if (hitExtra) begin
        prdata_q[7:0] <= extra_q;
      end else if (hitSeq) begin
        prdata_q[7:0] <= {1'b0, seqPend_q || (state_q == ST_SEQ),
                          seqCfg_q[5:0]};
      end else if (hitStat) begin
        prdata_q[STAT_SEQ_BIT]  <= (state_q == ST_SEQ);
        prdata_q[STAT_PEND_BIT] <= extraPend_q;
        prdata_q[STAT_EXT_BIT]  <= (state_q == ST_EXTRA);
        prdata_q[STAT_CH_LSB +: 4] <= active_q.chan;
      end
    end
  end

  assign prdata = prdata_q;

  // Conversion timer; its length follows the decimation code.
  // The decimation code of the active setting fixes both the length and
  // the resolution reported on resBits.
  aecc_conv uConv (
    .clk     (sys_clk),
    .rstN    (rstN),
    .start   (start_q),
    .decim   (active_q.decSel),
    .busy    (convBusy),
    .done    (convDone),
    .resBits (resBits)
  );

  // Analog selects for the active conversion.
  // The selects follow active_q one cycle later and hold between
  // conversions, so the front end sees no glitch.
  aecc_mux_dec uMux (
    .clk    (sys_clk),
    .rstN   (rstN),
    .cfg    (active_q),
    .muxSel (muxSel)
  );

  // Outputs for the front end; convActive covers the start cycle as well,
  // so it rises as soon as a conversion has been committed.
  assign convCfg    = active_q;
  assign convActive = convBusy || start_q;

endmodule
`default_nettype wire

//--- test/aecc_monitor.sv
// Port checker for the extra conversion control block.
// Assumes it is bound to aecc_top on the single sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
module aecc_monitor
  import aecc_pkg::*;
(
  input wire logic              sys_clk,    // Clock.
  input wire logic              arst_n,     // Reset, low.
  input wire logic              psel,       // Select.
  input wire logic              penable,    // Enable.
  input wire logic              pwrite,     // Write.
  input wire logic [ADDR_W-1:0] paddr,      // Address.
  input wire logic [31:0]       pwdata,     // Write data.
  input wire logic [31:0]       prdata,     // Read data.
  input wire logic              pslverr,    // Error.
  input wire aecc_conv_t        convCfg,    // Setting.
  input wire logic              convActive, // Running.
  input wire logic              convDone,   // End pulse.
  input wire logic [3:0]        resBits     // Resolution.
);
  logic [7:0]  lastWr_q; // Last byte written to the extra register.
  logic [12:0] runCnt_q; // Cycles since the conversion began.
  logic        act_q;    // Running flag one cycle back.
  logic        extWr;    // Write access to the extra register.
  logic        mapped;   // Address hits a register.

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Decode of the bus access.
  assign extWr  = psel && penable && pwrite && paddr == 12'h2d8;
  assign mapped = paddr == 12'h2d0 || paddr == 12'h2d4 || paddr == 12'h2d8;

  // Expected resolution of a decimation code.
  function automatic logic [3:0] expRes(logic [1:0] d);
    case (d)
      2'h0: return 4'h7;
      2'h1: return 4'h9;
      2'h2: return 4'ha;
      default: return 4'hc;
    endcase
  endfunction

  // Keeps the written byte and measures each conversion's length.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lastWr_q <= 8'h00;
      runCnt_q <= 13'h0000;
      act_q    <= 1'b0;
    end else begin
      act_q <= convActive;
      if (extWr) begin
        lastWr_q <= pwdata[7:0];
      end
      if (convDone) begin
        runCnt_q <= 13'h0000;
      end else if (convActive && !act_q) begin
        runCnt_q <= 13'h0001;
      end else if (runCnt_q != 13'h1fff) begin
        runCnt_q <= runCnt_q + 13'h0001;
      end
    end
  end

  // An extra write that finds the converter quiet.
  sequence s_idleWr;
    extWr && !convActive && !convDone && !$past(convDone)
      && !$past(convDone, 2);
  endsequence

  property p_startIdle;
    s_idleWr |-> ##2 (convActive && convCfg == aecc_conv_t'(lastWr_q));
  endproperty
  property p_resBits;
    $past(convActive) && convActive |-> resBits == expRes(convCfg.decSel);
  endproperty
  property p_runLen;
    convDone |-> runCnt_q + 13'h2 >= (13'h100 << convCfg.decSel)
      && runCnt_q <= (13'h100 << convCfg.decSel) + 13'h3;
  endproperty
  property p_minRun;
    $rose(convActive) |-> convActive [*8];
  endproperty
  property p_doneAfter;
    convDone |-> $past(convActive);
  endproperty
  property p_donePulse;
    convDone |=> !convDone;
  endproperty
  property p_slvErr;
    psel && penable |-> pslverr == !mapped;
  endproperty
  property p_rdHigh;
    psel && penable && !pwrite |-> prdata[31:8] == 24'h000000;
  endproperty

  a_startIdle: assert property (p_startIdle)
    else $error("extra conversion did not start as written");
  a_resBits: assert property (p_resBits)
    else $error("resolution does not match decimation");
  a_runLen: assert property (p_runLen)
    else $error("conversion length does not match decimation");
  a_minRun: assert property (p_minRun)
    else $error("conversion ended too soon");
  a_doneAfter: assert property (p_doneAfter)
    else $error("end pulse without a running conversion");
  a_donePulse: assert property (p_donePulse)
    else $error("end pulse longer than one cycle");
  a_slvErr: assert property (p_slvErr)
    else $error("bus error flag wrong for address");
  a_rdHigh: assert property (p_rdHigh)
    else $error("upper read data bits not zero");
endmodule

bind aecc_top aecc_monitor mon (.sys_clk, .arst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pslverr, .convCfg, .convActive, .convDone,
  .resBits);
`default_nettype wire

//--- test/test_adc_extra_conversion_control.sv
// Self-checking bench for the extra conversion control block.
// Assumes aecc_top with its checker bound, clocked at 40 MHz.
`timescale 1ns/1ps
`default_nettype none
module test_adc_extra_conversion_control import aecc_pkg::*;;
  logic              sys_clk = 1'b0;
  logic              arst_n  = 1'b0;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [ADDR_W-1:0] paddr   = '0;
  logic [31:0]       pwdata  = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  aecc_conv_t        convCfg;
  logic              convActive;
  logic              convDone;
  logic [3:0]        resBits;
  aecc_mux_t         muxSel;
  logic [31:0]       rnd = 32'hfb128e4a;
  int                mismatches = 0;
  int                n_tests = 0;
  int                cyc = 0;
  int                expQ[$];
  int                resTab[4] = '{7, 9, 10, 12};

  aecc_top uut (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .convCfg, .muxSel, .convActive,
    .convDone, .resBits);

  // Clock and hang guard.
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  // Shared helpers for stimulus and comparison.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Model of the analog selects for a setting, from the channel map.
  function automatic aecc_mux_t expMux(input logic [7:0] c);
    aecc_mux_t m;
    m = '0;
    if (c[3:0] < 4'h8) begin
      m.posSel[c[2:0]] = 1'b1;
    end else if (c[3:0] < 4'hc) begin
      m.posSel[2 * c[1:0]] = 1'b1;
      m.negSel[2 * c[1:0] + 1] = 1'b1;
    end else begin
      m.gndSel  = (c[1:0] == 2'h0);
      m.vrefSel = (c[1:0] == 2'h1);
      m.tempSel = (c[1:0] == 2'h2);
      m.vdd3Sel = (c[1:0] == 2'h3);
    end
    m.refOneHot[c[7:6]] = 1'b1;
    return m;
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] g);
    n_tests++;
    if (g !== ex) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, ex, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits for one conversion end and compares it with the model queue.
  task automatic result(output int t);
    int ex;
    do begin
      @(posedge sys_clk);
    end while (convDone !== 1'b1);
    t = cyc;
    ex = expQ.pop_front();
    chk("convCfg", ex, 32'(convCfg));
    chk("resBits", resTab[ex[5:4]], 32'(resBits));
    chk("muxSel", 32'(expMux(ex[7:0])), 32'(muxSel));
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  v;
    int          t0;
    int          t1;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    apb(1'b0, 12'h2d8, 8'h00, r, e);
    chk("extra reset", 32'h0, r);
    chk("slverr", 32'h0, 32'(e));
    $display("test reset values done");
    // One extra conversion from idle for every decimation and reference.
    for (int d = 0; d < 4; d++) begin
      rnd = xs(rnd);
      v = {2'(3 - d), 2'(d), rnd[3:0]};
      expQ.push_back(v);
      apb(1'b1, 12'h2d8, v, r, e);
      t0 = cyc;
      apb(1'b0, 12'h2d8, 8'h00, r, e);
      chk("extra pending", 32'(v), r);
      apb(1'b0, 12'h2d4, 8'h00, r, e);
      chk("status", {24'h0, v[3:0], 4'h4}, r);
      result(t1);
      chk("length", 32'h1, 32'((t1 - t0 >= (256 << d)) &&
          (t1 - t0 <= (256 << d) + 3)));
      apb(1'b0, 12'h2d8, 8'h00, r, e);
      chk("extra cleared", {24'h0, v[7:4], 4'h0}, r);
    end
    $display("test idle extra conversions done");
    // Two-input sequence with an extra request queued behind it.
    expQ.push_back(8'h00);
    expQ.push_back(8'h01);
    expQ.push_back(8'h95);
    apb(1'b1, 12'h2d0, 8'h41, r, e);
    apb(1'b1, 12'h2d8, 8'h95, r, e);
    apb(1'b0, 12'h2d4, 8'h00, r, e);
    chk("pending", 32'h3, r & 32'h3);
    repeat (3) result(t1);
    $display("test queued extra conversion done");
    // Access to an unmapped place is refused.
    apb(1'b0, 12'h100, 8'h00, r, e);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, r);
    $display("test unmapped access done");
    complete_run();
  end
endmodule
`default_nettype wire
